// ===== rtl/tc_pkg.sv
// timer/counter block: register indices, field layouts, reset values, rates
// assumes a 32-bit classic Wishbone slave with byte addresses, index = address / 4
package tc_pkg;

  localparam int ADR_W = 10;
  localparam int IDX_LSB = 2;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_T0_LOW = 8'h8a;
  localparam logic [7:0] IDX_T1_LOW = 8'h8b;
  localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
  localparam logic [7:0] IDX_T1_HIGH = 8'h8d;
  localparam logic [7:0] IDX_T2_CTRL = 8'hc8;
  localparam logic [7:0] IDX_T2_MODE = 8'hc9;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'hd0;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hd1;
  localparam logic [7:0] IDX_T2_LOW = 8'hd2;
  localparam logic [7:0] IDX_T2_HIGH = 8'hd3;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hd4;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hd5;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hd6;

  localparam int T01_N = 4;
  localparam logic [7:0] T01_IDX [T01_N] = '{IDX_T0_LOW, IDX_T1_LOW, IDX_T0_HIGH, IDX_T1_HIGH};
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // second timer control, bit 7 down to bit 0
  typedef struct packed {
    logic overflow_flag;
    logic external_toggle_flag;
    logic serial_receive_clock_select;
    logic serial_transmit_clock_select;
    logic external_enable;
    logic run_control_bit;
    logic counter_timer_select;
    logic capture_select;
  } second_timer_control_t;

  // second timer mode, bits 1 and 0; upper bits read zero
  typedef struct packed {
    logic clock_output_enable;
    logic up_down_enable;
  } second_timer_mode_t;

  localparam second_timer_control_t CTRL_RESET = '0;
  localparam second_timer_mode_t MODE_RESET = '0;

  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_SERIAL = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = '0;

  // input rate dividers, in sys_clk cycles per count
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] TIMER_DIV = 3'h6;
  localparam logic [DIV_W-1:0] FAST_DIV = 3'h2;
  localparam logic [DIV_W-1:0] DIV_START = 3'h1;

endpackage : tc_pkg

// ===== rtl/pin_sync.sv
// two flip-flop synchroniser, one chain per bit
// assumes inputs asynchronous to sys_clk
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        meta[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta[i] <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end
endmodule : pin_sync

// ===== rtl/rate_div.sv
// count-rate divider: one-cycle tick every TIMER_DIV or FAST_DIV cycles while run
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module rate_div
  import tc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic fast,
  output logic tick
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] limit;
  assign limit = fast ? FAST_DIV : TIMER_DIV;
  always_ff @(posedge sys_clk) begin
    if (!nrst || !run) begin
      cnt <= DIV_START;
      tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt <= DIV_START;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + DIV_START;
      tick <= 1'b0;
    end
  end
endmodule : rate_div

// ===== rtl/timer_counter_with_clock_out.sv
// timer/counter unit: 16-bit second timer with auto-reload, up/down and clock-out,
// plus the byte count registers of timers 0 and 1, on a classic Wishbone slave
// assumes one 125 MHz sys_clk, synchronous active-low reset, asynchronous pins
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

module timer_counter_with_clock_out
  import tc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_clockout_pin_in,
  output logic count_clockout_pin_out,
  output logic count_clockout_pin_oe_n,
  input wire logic direction_pin,
  input wire logic timer1_overflow,
  output logic serial_receive_tick,
  output logic serial_transmit_tick,
  output logic irq
);

  second_timer_control_t ctrl;
  second_timer_mode_t mode;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [15:0] reload;
  logic [7:0] t01 [T01_N];
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [1:0] pin_sync_q;
  logic pin_prev;
  logic pin_fall;
  logic div_tick;
  logic count_tick;
  logic count_up;
  logic wrap;
  logic clkout_mode;
  logic serial_mode;
  logic fast_rate;
  logic set_overflow;
  logic bus_hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  second_timer_control_t wctrl;
  logic wr_en;
  logic wr_count;
  logic [7:0] rd_byte;

  // pins and direction from outside the clock domain
  pin_sync #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({direction_pin, count_clockout_pin_in}),
    .sync_out(pin_sync_q)
  );

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_sync_q[0];
    end
  end

  assign pin_fall = pin_prev & ~pin_sync_q[0];

  assign clkout_mode = mode.clock_output_enable & ~ctrl.counter_timer_select;
  assign serial_mode = ctrl.serial_receive_clock_select | ctrl.serial_transmit_clock_select;
  assign fast_rate = clkout_mode | serial_mode;

  rate_div u_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(ctrl.run_control_bit),
    .fast(fast_rate),
    .tick(div_tick)
  );

  // source select and run gate
  assign count_tick = ctrl.run_control_bit &
                      (ctrl.counter_timer_select ? pin_fall : div_tick);

  // direction: up unless up/down is enabled, the pin is low and clock-out is off
  assign count_up = ~mode.up_down_enable | pin_sync_q[1] | clkout_mode;

  always_comb begin
    next_count = count;
    wrap = 1'b0;
    if (count_tick) begin
      if (count_up) begin
        if (count == COUNT_MAX) begin
          next_count = reload;
          wrap = 1'b1;
        end else begin
          next_count = count + COUNT_STEP;
        end
      end else if (count == reload) begin
        next_count = COUNT_MAX;
        wrap = 1'b1;
      end else begin
        next_count = count - COUNT_STEP;
      end
    end
  end

  assign set_overflow = wrap & ~clkout_mode & ~serial_mode;

  // Wishbone classic slave: ack one cycle after the request, write at the ack edge
  assign bus_hit = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
  assign wbyte = wb_dat_i[7:0];
  assign wctrl = second_timer_control_t'(wbyte);
  assign wr_en = bus_hit & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wr_count = wr_en & ((idx == IDX_T2_LOW) | (idx == IDX_T2_HIGH));

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_hit & ~wb_ack_o;
    end
  end

  always_comb begin
    rd_byte = BYTE_RESET;
    case (idx)
      IDX_T2_CTRL: rd_byte = ctrl;
      IDX_T2_MODE: rd_byte = {6'h00, mode};
      IDX_RELOAD_LOW: rd_byte = reload[7:0];
      IDX_RELOAD_HIGH: rd_byte = reload[15:8];
      IDX_T2_LOW: rd_byte = count[7:0];
      IDX_T2_HIGH: rd_byte = count[15:8];
      IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status};
      IDX_IRQ_ENABLE: rd_byte = {6'h00, irq_enable};
      default: begin
        for (int i = 0; i < T01_N; i++) begin
          if (idx == T01_IDX[i]) begin
            rd_byte = t01[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_hit & ~wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // timers 0 and 1: byte registers, only written and read over the bus, never counted
  for (genvar i = 0; i < T01_N; i++) begin : g_t01
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        t01[i] <= BYTE_RESET;
      end else if (wr_en && idx == T01_IDX[i]) begin
        t01[i] <= wbyte;
      end
    end
  end

  // second timer count: a software write wins over a tick in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count <= COUNT_RESET;
    end else if (wr_en && idx == IDX_T2_LOW) begin
      count <= {count[15:8], wbyte};
    end else if (wr_en && idx == IDX_T2_HIGH) begin
      count <= {wbyte, count[7:0]};
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reload <= COUNT_RESET;
    end else if (wr_en && idx == IDX_RELOAD_LOW) begin
      reload <= {reload[15:8], wbyte};
    end else if (wr_en && idx == IDX_RELOAD_HIGH) begin
      reload <= {wbyte, reload[7:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode <= MODE_RESET;
    end else if (wr_en && idx == IDX_T2_MODE) begin
      mode <= wbyte[1:0];
    end
  end

  // control: hardware set of a flag wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
    end else begin
      if (wr_en && idx == IDX_T2_CTRL) begin
        ctrl <= wbyte;
      end
      if (set_overflow) begin
        ctrl.overflow_flag <= 1'b1;
      end
      if (wrap && mode.up_down_enable && !clkout_mode) begin
        ctrl.external_toggle_flag <= (wr_en && idx == IDX_T2_CTRL) ?
          ~wctrl.external_toggle_flag : ~ctrl.external_toggle_flag;
      end
    end
  end

  // clock-out: toggle per wrap at half-rate ticks gives clk / (4 * (65536 - reload))
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count_clockout_pin_out <= 1'b0;
      count_clockout_pin_oe_n <= 1'b1;
    end else begin
      count_clockout_pin_oe_n <= ~clkout_mode;
      if (!clkout_mode) begin
        count_clockout_pin_out <= 1'b0;
      end else if (wrap) begin
        count_clockout_pin_out <= ~count_clockout_pin_out;
      end
    end
  end

  // serial port clocks
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      serial_receive_tick <= 1'b0;
      serial_transmit_tick <= 1'b0;
    end else begin
      serial_receive_tick <= ctrl.serial_receive_clock_select ? wrap : timer1_overflow;
      serial_transmit_tick <= ctrl.serial_transmit_clock_select ? wrap : timer1_overflow;
    end
  end

  // interrupt status, enable and level output
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_status <= IRQ_RESET;
    end else begin
      if (wr_en && idx == IDX_IRQ_CLEAR) begin
        irq_status <= irq_status & ~wbyte[IRQ_W-1:0];
      end
      if (set_overflow) begin
        irq_status[IRQ_OVERFLOW] <= 1'b1;
      end
      if (wrap && serial_mode) begin
        irq_status[IRQ_SERIAL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_enable <= IRQ_RESET;
    end else if (wr_en && idx == IDX_IRQ_ENABLE) begin
      irq_enable <= wbyte[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // checks
  up_wrap_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    count_tick && count_up && count == COUNT_MAX && !wr_count |=> count == $past(reload))
    else $error("up wrap did not load reload pair");

  down_wrap_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    count_tick && !count_up && count == reload && !wr_count |=> count == COUNT_MAX)
    else $error("down wrap did not load all ones");

  run_gate_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !ctrl.run_control_bit && !wr_count |=> $stable(count))
    else $error("count moved while stopped");

  up_only_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    count_tick && !mode.up_down_enable && count != COUNT_MAX && !wr_count
    |=> count == 16'($past(count) + COUNT_STEP))
    else $error("count did not step up");

  flag_set_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    wrap && !clkout_mode && !serial_mode |=> ctrl.overflow_flag && irq_status[IRQ_OVERFLOW])
    else $error("overflow flag or request missing");

  flag_hold_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (serial_mode || clkout_mode) && !ctrl.overflow_flag && !(wr_en && idx == IDX_T2_CTRL)
    |=> !ctrl.overflow_flag)
    else $error("overflow flag set by hardware in serial or clock-out use");

  toggle_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    wrap && mode.up_down_enable && !clkout_mode && !(wr_en && idx == IDX_T2_CTRL)
    |=> ctrl.external_toggle_flag != $past(ctrl.external_toggle_flag))
    else $error("external toggle flag did not flip");

  clock_out_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    wrap && clkout_mode |=> count_clockout_pin_out != $past(count_clockout_pin_out)
    && !count_clockout_pin_oe_n)
    else $error("clock output did not toggle");

  half_rate_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    div_tick && fast_rate && ctrl.run_control_bit ##1 fast_rate && ctrl.run_control_bit
    |-> !div_tick ##1 div_tick)
    else $error("clock-out rate is not half the clock");

  serial_clk_a: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    wrap && ctrl.serial_receive_clock_select |=> serial_receive_tick)
    else $error("serial receive clock missed a wrap");

endmodule : timer_counter_with_clock_out

// ===== dv/pin_partner.sv
// far-side model of the count/clock-out pin and the direction pin
// assumes a pull-up on the count pin and the block drives it only while oe_n is low
`timescale 1ns/1ps
module pin_partner (
  input wire logic sys_clk,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic dir_level,
  output logic pin_level,
  output logic direction_pin
);
  logic ext_drive = 1'b1;

  // block output wins while enabled, else our driver over the pull-up
  assign pin_level = pin_oe_n ? ext_drive : pin_out;
  assign direction_pin = dir_level;

  // n falling edges on the pin, each level held for hold cycles
  task automatic falls(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge sys_clk);
      ext_drive <= 1'b0;
      repeat (hold) @(posedge sys_clk);
      ext_drive <= 1'b1;
    end
  endtask : falls
endmodule : pin_partner

// ===== dv/tb_timer_counter_with_clock_out.sv
// testbench of the timer/counter block: Wishbone register tests and pin checks
// assumes the pin partner model and the tc_pkg register map
`timescale 1ns/1ps
module tb_timer_counter_with_clock_out
  import tc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_r;
  logic ack, pin_out, pin_oe_n, pin_level, dir_pin, rx_tick, tx_tick, irq, prv;
  logic dir_level = 1'b1;
  logic t1_ovf = 1'b0;
  logic [7:0] q;
  int n_mismatch = 0;
  int checks = 0;
  int tx_count = 0;
  int rx_count = 0;
  int r0, r1, hi;

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (tx_tick === 1'b1) tx_count++;
    if (rx_tick === 1'b1) rx_count++;
  end

  timer_counter_with_clock_out u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .count_clockout_pin_in(pin_level), .count_clockout_pin_out(pin_out),
    .count_clockout_pin_oe_n(pin_oe_n), .direction_pin(dir_pin),
    .timer1_overflow(t1_ovf), .serial_receive_tick(rx_tick),
    .serial_transmit_tick(tx_tick), .irq(irq)
  );

  pin_partner u_pin (
    .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .dir_level(dir_level),
    .pin_level(pin_level), .direction_pin(dir_pin)
  );

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // one classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rq);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= {idx, 2'b00};
    dat_w <= {24'h00_0000, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rq = dat_r[7:0];
    if (n >= 50) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] rq;
    bus(1'b1, idx, wd, rq);
  endtask : wr

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] rq;
    bus(1'b0, idx, 8'h00, rq);
    chk(name, {8'h00, exp}, {8'h00, rq});
  endtask : rd_chk

  task automatic load(input logic [7:0] i_lo, input logic [7:0] v_lo, input logic [7:0] v_hi);
    wr(i_lo, v_lo);
    wr(i_lo + 8'h01, v_hi);
  endtask : load

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < T01_N; i++) rd_chk("t01 reset", T01_IDX[i], BYTE_RESET);
    for (int i = 0; i < T01_N; i++) wr(T01_IDX[i], 8'h5a + 8'(i));
    for (int i = 0; i < T01_N; i++) rd_chk("t01 rw", T01_IDX[i], 8'h5a + 8'(i));
    wr(8'h10, 8'hff);
    rd_chk("unmapped", 8'h10, 8'h00);
    rd_chk("clear reg", IDX_IRQ_CLEAR, 8'h00);
    $display("test registers done");
    // timer rate: one count per six clocks, frozen when run is off
    wr(IDX_T2_CTRL, 8'h04);
    repeat (600) @(posedge sys_clk);
    wr(IDX_T2_CTRL, 8'h00);
    bus(1'b0, IDX_T2_LOW, 8'h00, q);
    chk("rate in range", 16'h0001, 16'((q >= 8'h62) && (q <= 8'h67)));
    rd_chk("rate high", IDX_T2_HIGH, 8'h00);
    repeat (60) @(posedge sys_clk);
    rd_chk("stopped", IDX_T2_LOW, q);
    $display("test rate done");
    // up count with up/down disabled, direction low
    dir_level <= 1'b0;
    wr(IDX_IRQ_ENABLE, 8'h01);
    load(IDX_RELOAD_LOW, 8'h34, 8'h12);
    load(IDX_T2_LOW, 8'hfe, 8'hff);
    wr(IDX_T2_CTRL, 8'h04);
    repeat (30) @(posedge sys_clk);
    bus(1'b0, IDX_T2_CTRL, 8'h00, q);
    wr(IDX_T2_CTRL, q & 8'hfb);
    rd_chk("reload high", IDX_T2_HIGH, 8'h12);
    chk("ovf flag", 16'h0001, {15'h0000, q[7]});
    rd_chk("status", IDX_IRQ_STATUS, 8'h01);
    chk("irq on", 16'h0001, {15'h0000, irq});
    wr(IDX_IRQ_ENABLE, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(IDX_IRQ_ENABLE, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("irq unmasked", 16'h0001, {15'h0000, irq});
    wr(IDX_IRQ_CLEAR, 8'h01);
    wr(IDX_T2_CTRL, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    rd_chk("status clr", IDX_IRQ_STATUS, 8'h00);
    $display("test auto reload done");
    // down count: equal to reload gives FFFFh, both flags set
    wr(IDX_T2_MODE, 8'h01);
    load(IDX_RELOAD_LOW, 8'h10, 8'h00);
    load(IDX_T2_LOW, 8'h12, 8'h00);
    wr(IDX_T2_CTRL, 8'h04);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, IDX_T2_CTRL, 8'h00, q);
    wr(IDX_T2_CTRL, q & 8'hfb);
    rd_chk("underflow high", IDX_T2_HIGH, 8'hff);
    chk("down flags", 16'h0003, {14'h0000, q[7:6]});
    wr(IDX_T2_CTRL, 8'h00);
    // up/down enabled with the direction pin high: counts up, wraps to the reload pair
    dir_level <= 1'b1;
    load(IDX_T2_LOW, 8'hfe, 8'hff);
    wr(IDX_T2_CTRL, 8'h04);
    repeat (20) @(posedge sys_clk);
    bus(1'b0, IDX_T2_CTRL, 8'h00, q);
    wr(IDX_T2_CTRL, q & 8'hfb);
    rd_chk("up reload", IDX_T2_HIGH, 8'h00);
    chk("up flags", 16'h0003, {14'h0000, q[7:6]});
    wr(IDX_T2_CTRL, 8'h00);
    wr(IDX_T2_MODE, 8'h00);
    wr(IDX_IRQ_CLEAR, 8'h01);
    $display("test down count done");
    // counter operation on pin falling edges
    load(IDX_T2_LOW, 8'h00, 8'h00);
    wr(IDX_T2_CTRL, 8'h06);
    u_pin.falls(5, 4);
    repeat (8) @(posedge sys_clk);
    wr(IDX_T2_CTRL, 8'h00);
    rd_chk("pin count", IDX_T2_LOW, 8'h05);
    $display("test counter done");
    // clock-out set up in the documented order
    wr(IDX_T2_MODE, 8'h02);
    wr(IDX_T2_CTRL, 8'h00);
    load(IDX_RELOAD_LOW, 8'hfe, 8'hff);
    load(IDX_T2_LOW, 8'hfe, 8'hff);
    wr(IDX_T2_CTRL, 8'h04);
    r0 = 0;
    r1 = 0;
    hi = 0;
    prv = pin_level;
    for (int i = 1; i < 200 && r1 == 0; i++) begin
      @(posedge sys_clk);
      if (pin_level === 1'b1 && prv === 1'b0) begin
        if (r0 == 0) r0 = i;
        else r1 = i;
      end else if (pin_level === 1'b1 && r0 != 0) hi++;
      prv = pin_level;
    end
    chk("pin enabled", 16'h0000, {15'h0000, pin_oe_n});
    chk("period", 16'(4 * (65536 - 65534)), 16'(r1 - r0));
    chk("high time", 16'(2 * (65536 - 65534)), 16'(hi + 1));
    wr(IDX_T2_CTRL, 8'h00);
    rd_chk("no request", IDX_IRQ_STATUS, 8'h00);
    chk("no irq", 16'h0000, {15'h0000, irq});
    wr(IDX_T2_MODE, 8'h00);
    $display("test clock out done");
    // serial clock select: wraps feed the serial port, flag stays clear
    load(IDX_RELOAD_LOW, 8'hf0, 8'hff);
    load(IDX_T2_LOW, 8'hfe, 8'hff);
    tx_count = 0;
    rx_count = 0;
    wr(IDX_T2_CTRL, 8'h34);
    repeat (80) @(posedge sys_clk);
    bus(1'b0, IDX_T2_CTRL, 8'h00, q);
    wr(IDX_T2_CTRL, 8'h00);
    chk("tx ticks", 16'h0001, 16'(tx_count > 0));
    chk("flag held", 16'h0000, {15'h0000, q[7]});
    chk("rx ticks", 16'h0001, 16'(rx_count > 0));
    rd_chk("serial status", IDX_IRQ_STATUS, 8'h02);
    rx_count = 0;
    @(posedge sys_clk);
    t1_ovf <= 1'b1;
    @(posedge sys_clk);
    t1_ovf <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("rx from t1", 16'h0001, 16'(rx_count));
    $display("test serial done");
    end_sim();
  end
endmodule : tb_timer_counter_with_clock_out
